/* hw/srp_mode_ctrl.sv */
// Serial register port and operating-mode sequencer of the transmitter
//
// Notes on behaviour
// - Frames: direction bit, 7-bit address, data byte.
// - Direction one writes, zero reads.
// - Address picks one of 128 byte registers.
// - Address and data captured every eight clocks.
// - Read ignores the data bits shifted in.
// - Read data leaves on next eight falling edges.
// - Output holds last bit until select released.
// - Select high: output released, pulled high.
// - Burst: address increments after every byte.
// - Power-down pin: lowest power, registers lost.
// - Falling power-down edge starts power-on reset.
// - Every reset ends in idle ready mode.
// - Mode zero: standby, low-power regulator only.
// - Wake-timer bit selects sleep with timer.
// - Battery-detect bit turns detector on.
// - Crystal keep-on bit selects ready mode.
// - Synth keep-on: tune mode, crystal forced on.
// - Transmit request runs sequencer, skipping satisfied steps.
// - Calibration skipped when enable bit clear.
`timescale 1ns/1ps
`default_nettype none

module srp_mode_ctrl
	import srp_pkg::*;
#(
	parameter logic [`SRP_TMR_W-1:0] POR_CYCLES    = `SRP_TMR_W'(`SRP_POR_CYC),
	parameter logic [`SRP_TMR_W-1:0] SOFT_CYCLES   = `SRP_TMR_W'(`SRP_SOFT_CYC),
	parameter logic [`SRP_TMR_W-1:0] XTAL_CYCLES   = `SRP_TMR_W'(`SRP_XTAL_CYC),
	parameter logic [`SRP_TMR_W-1:0] CAL_CYCLES    = `SRP_TMR_W'(`SRP_CAL_CYC),
	parameter logic [`SRP_TMR_W-1:0] SETTLE_CYCLES =
		`SRP_TMR_W'(`SRP_SETTLE_CYC)
)
(
	input  wire logic       clock,              // Core clock, 250 MHz
	input  wire logic       sys_rst,            // Synchronous reset
	input  wire logic       clk_en,             // Freezes state when low
	input  wire logic       sclk,               // Serial clock from host
	input  wire logic       sdi,                // Serial data in
	input  wire logic       chip_select_n,      // Frame select, low
	input  wire logic       power_down_pin,     // Shutdown request, high
	output logic            sdo,                // Serial data out
	output logic            sdo_oe,             // High while driving sdo
	output logic            low_power_regulator,// Low-power regulator on
	output logic            main_regulator,     // Main regulator on
	output logic            wake_timer_on,      // Wake-up timer running
	output logic            battery_detect_on,  // Low battery detector on
	output logic            xtal_osc_on,        // Crystal oscillator on
	output logic            synth_on,           // Synthesizer enabled
	output logic            cal_active,         // Oscillator calibration
	output logic            pa_on,              // Amplifier on or ramping
	output logic            tx_active,          // Transmitting
	output logic      [3:0] radio_state         // Current state code
);

	// ------------------------------------------------------------------
	// Local constants
	// ------------------------------------------------------------------
	localparam logic [`SRP_TMR_W-1:0] RAMP_CYCLES =
		`SRP_TMR_W'(`SRP_RAMP_CYC);

	// ------------------------------------------------------------------
	// Helper functions
	// ------------------------------------------------------------------

	// Register contents after any reset or shutdown
	function automatic srp_regs_t default_regs();
		srp_regs_t d;
		d                   = {`SRP_NUM_REGS{`SRP_OTHER_RST}};
		d[`SRP_REG_MODE]    = `SRP_MODE_RST;
		d[`SRP_REG_CALCTL]  = `SRP_CALCTL_RST;
		d[`SRP_REG_XTAL]    = `SRP_XTAL_RST;
		return d;
	endfunction : default_regs

	// Next address of a burst, wraps within the 128 registers
	function automatic logic [`SRP_ADDR_W-1:0] next_addr(
		input logic [`SRP_ADDR_W-1:0] a
	);
		return a + `SRP_ADDR_W'(1);
	endfunction : next_addr

	// Block enables for a state and a mode register value
	function automatic srp_pwr_s power_of(
		input srp_state_e            st,
		input logic [`SRP_DATA_W-1:0] m
	);
		srp_pwr_s p;
		p = '0;
		unique case (st)
			SRP_SHDN:
			begin
				p = '0;
			end
			SRP_POR, SRP_SWRST:
			begin
				p.main_reg = 1'b1;
			end
			SRP_IDLE:
			begin
				// Synth keep-on forces crystal on too
				p.xtal     = m[`SRP_MODE_XTON] | m[`SRP_MODE_PLLON];
				p.synth    = m[`SRP_MODE_PLLON];
				p.lbd      = m[`SRP_MODE_ENLBD];
				p.wut      = m[`SRP_MODE_ENWT];
				p.main_reg = p.xtal | p.lbd;
				p.lp_reg   = ~p.main_reg;
			end
			SRP_XTAL, SRP_PLLEN:
			begin
				p.main_reg = 1'b1;
				p.xtal     = 1'b1;
				p.synth    = (st == SRP_PLLEN);
			end
			SRP_CAL, SRP_SETTLE:
			begin
				p.main_reg = 1'b1;
				p.xtal     = 1'b1;
				p.synth    = 1'b1;
				p.cal      = (st == SRP_CAL);
			end
			SRP_RAMP, SRP_TX:
			begin
				p.main_reg = 1'b1;
				p.xtal     = 1'b1;
				p.synth    = 1'b1;
				p.pa       = 1'b1;
				p.tx       = (st == SRP_TX);
			end
			default:
			begin
				p = '0;
			end
		endcase
		return p;
	endfunction : power_of

	// Reset image of the whole state
	function automatic srp_core_s core_reset();
		srp_core_s c;
		c       = '0;
		c.state = SRP_SHDN;
		c.regs  = default_regs();
		c.sdo   = 1'b1;
		return c;
	endfunction : core_reset

	localparam srp_core_s CORE_RST = core_reset();

	// ------------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------------
	srp_core_s              r;          // Registered state
	srp_core_s              next_r;     // Next state
	logic [3:0]             pins_sync;  // {pdn, csn, sdi, sclk}
	logic                   sclk_s;     // Synchronised serial clock
	logic                   sdi_s;      // Synchronised data in
	logic                   csn_s;      // Synchronised select
	logic                   pdn_s;      // Synchronised power-down
	logic                   tmr_load;   // Start a timed wait
	logic [`SRP_TMR_W-1:0]  tmr_val;    // Length of that wait
	logic                   tmr_done;   // Wait has elapsed

	// ------------------------------------------------------------------
	// Pin synchroniser and step timer
	// ------------------------------------------------------------------
	srp_sync u_sync (
		.clock     (clock),
		.sys_rst   (sys_rst),
		.clk_en    (clk_en),
		.pins_in   ({power_down_pin, chip_select_n, sdi, sclk}),
		.pins_sync (pins_sync)
	);

	srp_delay_timer u_timer (
		.clock    (clock),
		.sys_rst  (sys_rst),
		.clk_en   (clk_en),
		.load     (tmr_load),
		.load_val (tmr_val),
		.done     (tmr_done)
	);

	assign pdn_s  = pins_sync[3];
	assign csn_s  = pins_sync[2];
	assign sdi_s  = pins_sync[1];
	assign sclk_s = pins_sync[0];

	// ------------------------------------------------------------------
	// Next-state logic: serial engine then radio state machine
	// ------------------------------------------------------------------
	always_comb
	begin
		logic                    rise;     // Serial clock rising
		logic                    fall;     // Serial clock falling
		logic                    serial_ok;// Port usable in this state
		logic                    soft_go;  // Soft reset written
		logic [`SRP_DATA_W-1:0]  sh;       // Shift value after rise
		logic [`SRP_DATA_W-1:0]  mode;     // Mode register, next value
		rise      = 1'b0;
		fall      = 1'b0;
		serial_ok = 1'b0;
		soft_go   = 1'b0;
		sh        = '0;
		mode      = '0;
		next_r    = r;
		tmr_load  = 1'b0;
		tmr_val   = '0;

		// Edge detection on the stable serial clock
		next_r.sclk_d = sclk_s;
		rise          = sclk_s & ~r.sclk_d;
		fall          = ~sclk_s & r.sclk_d;
		serial_ok     = (r.state != SRP_SHDN) && (r.state != SRP_POR) &&
			(r.state != SRP_SWRST);

		// -------------------------------------------------------------
		// Serial frame engine
		// -------------------------------------------------------------
		if (csn_s || !serial_ok)
		begin
			// Released select: drop frame, let pull-up win
			next_r.bitcnt   = '0;
			next_r.hdr_done = 1'b0;
			next_r.sdo      = 1'b1;
			next_r.sdo_oe   = 1'b0;
		end
		else
		begin
			next_r.sdo_oe = 1'b1;
			if (rise)
			begin
				// Sample on rising edge, MSB first
				sh            = {r.shreg[`SRP_DATA_W-2:0], sdi_s};
				next_r.shreg  = sh;
				next_r.bitcnt = r.bitcnt + 3'h1;
				if (r.bitcnt == `SRP_BITCNT_LAST)
				begin
					if (!r.hdr_done)
					begin
						// Header byte: direction, then address
						next_r.hdr_done = 1'b1;
						next_r.is_write = sh[`SRP_DATA_W-1];
						next_r.addr     = sh[`SRP_ADDR_W-1:0];
						next_r.out_sr   = r.regs[sh[`SRP_ADDR_W-1:0]];
					end
					else if (r.is_write)
					begin
						// Data byte of a write, then move on
						next_r.regs[r.addr] = sh;
						next_r.addr         = next_addr(r.addr);
						if (r.addr == `SRP_REG_MODE)
						begin
							soft_go = sh[`SRP_MODE_SWRES];
							next_r.regs[r.addr][`SRP_MODE_SWRES] = 1'b0;
						end
					end
					else
					begin
						// Read: input byte dropped, next register staged
						next_r.addr   = next_addr(r.addr);
						next_r.out_sr = r.regs[next_addr(r.addr)];
					end
				end
			end
			else if (fall && r.hdr_done && !r.is_write)
			begin
				// Shift out on falling edges; last bit holds
				next_r.sdo    = r.out_sr[`SRP_DATA_W-1];
				next_r.out_sr = {r.out_sr[`SRP_DATA_W-2:0], 1'b0};
			end
		end

		mode = next_r.regs[`SRP_REG_MODE];

		// -------------------------------------------------------------
		// Radio state machine and transmit sequencer
		// -------------------------------------------------------------
		unique case (r.state)
			SRP_SHDN:
			begin
				// Leaving shutdown starts a power-on reset
				if (!pdn_s)
				begin
					next_r.state = SRP_POR;
					tmr_load     = 1'b1;
					tmr_val      = POR_CYCLES;
				end
			end
			SRP_POR, SRP_SWRST:
			begin
				// Both resets end in idle ready mode
				if (tmr_done)
				begin
					next_r.state = SRP_IDLE;
				end
			end
			SRP_IDLE:
			begin
				// Skip steps already running in this idle mode
				if (mode[`SRP_MODE_TXON])
				begin
					if (mode[`SRP_MODE_PLLON])
					begin
						next_r.state = SRP_RAMP;
						tmr_load     = 1'b1;
						tmr_val      = RAMP_CYCLES;
					end
					else if (mode[`SRP_MODE_XTON])
					begin
						next_r.state = SRP_PLLEN;
					end
					else
					begin
						next_r.state = SRP_XTAL;
						tmr_load     = 1'b1;
						tmr_val      = XTAL_CYCLES;
					end
				end
			end
			SRP_XTAL:
			begin
				// Crystal start-up wait
				if (tmr_done)
				begin
					next_r.state = SRP_PLLEN;
				end
			end
			SRP_PLLEN:
			begin
				// Calibrate only when enabled
				tmr_load = 1'b1;
				if (r.regs[`SRP_REG_CALCTL][`SRP_CALCTL_CALEN])
				begin
					next_r.state = SRP_CAL;
					tmr_val      = CAL_CYCLES;
				end
				else
				begin
					next_r.state = SRP_SETTLE;
					tmr_val      = SETTLE_CYCLES;
				end
			end
			SRP_CAL:
			begin
				// Calibration over, synthesizer settles
				if (tmr_done)
				begin
					next_r.state = SRP_SETTLE;
					tmr_load     = 1'b1;
					tmr_val      = SETTLE_CYCLES;
				end
			end
			SRP_SETTLE:
			begin
				// Settled, amplifier ramps
				if (tmr_done)
				begin
					next_r.state = SRP_RAMP;
					tmr_load     = 1'b1;
					tmr_val      = RAMP_CYCLES;
				end
			end
			SRP_RAMP:
			begin
				// Ramp complete, transmit
				if (tmr_done)
				begin
					next_r.state = SRP_TX;
				end
			end
			SRP_TX:
			begin
				// Stay while transmit is requested
				next_r.state = SRP_TX;
			end
			default:
			begin
				next_r.state = SRP_SHDN;
			end
		endcase

		// Dropping the transmit request returns to idle
		if ((r.state inside {SRP_XTAL, SRP_PLLEN, SRP_CAL, SRP_SETTLE,
			SRP_RAMP, SRP_TX}) && !mode[`SRP_MODE_TXON])
		begin
			next_r.state = SRP_IDLE;
		end

		// Soft reset restores registers and waits out its time
		if (soft_go)
		begin
			next_r.state = SRP_SWRST;
			next_r.regs  = default_regs();
			tmr_load     = 1'b1;
			tmr_val      = SOFT_CYCLES;
		end

		// Power-down pin overrides everything, contents lost
		if (pdn_s)
		begin
			next_r.state    = SRP_SHDN;
			next_r.regs     = default_regs();
			next_r.hdr_done = 1'b0;
			next_r.bitcnt   = '0;
			next_r.sdo      = 1'b1;
			next_r.sdo_oe   = 1'b0;
			tmr_load        = 1'b0;
		end

		// Registered block enables follow the next state
		next_r.pwr = power_of(next_r.state, next_r.regs[`SRP_REG_MODE]);
	end

	// ------------------------------------------------------------------
	// State register
	// ------------------------------------------------------------------
	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			r <= CORE_RST;
		end
		else if (clk_en)
		begin
			r <= next_r;
		end
	end

	// ------------------------------------------------------------------
	// Outputs, all from flip-flops
	// ------------------------------------------------------------------
	assign sdo                 = r.sdo;
	assign sdo_oe              = r.sdo_oe;
	assign low_power_regulator = r.pwr.lp_reg;
	assign main_regulator      = r.pwr.main_reg;
	assign wake_timer_on       = r.pwr.wut;
	assign battery_detect_on   = r.pwr.lbd;
	assign xtal_osc_on         = r.pwr.xtal;
	assign synth_on            = r.pwr.synth;
	assign cal_active          = r.pwr.cal;
	assign pa_on               = r.pwr.pa;
	assign tx_active           = r.pwr.tx;
	assign radio_state         = r.state;

endmodule : srp_mode_ctrl

`default_nettype wire

/* inc/srp_map.svh */
// Offsets, field positions, reset values and timing counts of the port
`ifndef SRP_MAP_SVH
`define SRP_MAP_SVH

// ----------------------------------------------------------------------
// Serial frame geometry
// ----------------------------------------------------------------------
`define SRP_ADDR_W        7
`define SRP_DATA_W        8
`define SRP_NUM_REGS      128
`define SRP_BITCNT_LAST   3'h7

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define SRP_REG_MODE      7'h07
`define SRP_REG_XTAL      7'h62
`define SRP_REG_CALCTL    7'h55

// ----------------------------------------------------------------------
// Field positions in operating_mode_control and in the calibration control register
// ----------------------------------------------------------------------
`define SRP_MODE_XTON     0
`define SRP_MODE_PLLON    1
`define SRP_MODE_TXON     3
`define SRP_MODE_ENLBD    5
`define SRP_MODE_ENWT     6
`define SRP_MODE_SWRES    7
`define SRP_CALCTL_CALEN  3

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define SRP_MODE_RST      8'h01
`define SRP_CALCTL_RST    8'h08
`define SRP_XTAL_RST      8'h00
`define SRP_OTHER_RST     8'h00
`define SRP_SYNC_RST      4'hc

// ----------------------------------------------------------------------
// Timing: printed times and derived cycle counts at the core clock
// ----------------------------------------------------------------------
`define SRP_CLK_MHZ       250
`define SRP_TMR_W         22
`define SRP_T_POR_MS      16
`define SRP_T_SOFT_US     100
`define SRP_T_XTAL_US     600
`define SRP_T_CAL_US      100
`define SRP_T_SETTLE_US   100
`define SRP_T_RAMP_US     5
`define SRP_POR_CYC       (`SRP_T_POR_MS * 1000 * `SRP_CLK_MHZ)
`define SRP_SOFT_CYC      (`SRP_T_SOFT_US * `SRP_CLK_MHZ)
`define SRP_XTAL_CYC      (`SRP_T_XTAL_US * `SRP_CLK_MHZ)
`define SRP_CAL_CYC       (`SRP_T_CAL_US * `SRP_CLK_MHZ)
`define SRP_SETTLE_CYC    (`SRP_T_SETTLE_US * `SRP_CLK_MHZ)
`define SRP_RAMP_CYC      (`SRP_T_RAMP_US * `SRP_CLK_MHZ)

`endif

/* inc/srp_pkg.sv */
// Types shared by the serial register port and its mode controller
`include "srp_map.svh"

package srp_pkg;

	// ------------------------------------------------------------------
	// Radio state machine, Gray codes along the transmit path
	// ------------------------------------------------------------------
	typedef enum logic [3:0] {
		SRP_SHDN   = 4'h0,
		SRP_POR    = 4'h1,
		SRP_IDLE   = 4'h3,
		SRP_XTAL   = 4'h2,
		SRP_PLLEN  = 4'h6,
		SRP_CAL    = 4'h7,
		SRP_SETTLE = 4'h5,
		SRP_RAMP   = 4'h4,
		SRP_TX     = 4'hc,
		SRP_SWRST  = 4'hb
	} srp_state_e;

	// Block enables driven toward the analog side
	typedef struct packed {
		logic lp_reg;
		logic main_reg;
		logic wut;
		logic lbd;
		logic xtal;
		logic synth;
		logic cal;
		logic pa;
		logic tx;
	} srp_pwr_s;

	typedef logic [`SRP_NUM_REGS-1:0][`SRP_DATA_W-1:0] srp_regs_t;

	// Whole state of the main controller
	typedef struct packed {
		srp_state_e                state;
		srp_pwr_s                  pwr;
		srp_regs_t                 regs;
		logic                      sclk_d;
		logic [2:0]                bitcnt;
		logic                      hdr_done;
		logic                      is_write;
		logic [`SRP_ADDR_W-1:0]    addr;
		logic [`SRP_DATA_W-1:0]    shreg;
		logic [`SRP_DATA_W-1:0]    out_sr;
		logic                      sdo;
		logic                      sdo_oe;
	} srp_core_s;

	typedef struct packed {
		logic [3:0] meta;
		logic [3:0] stable;
	} srp_sync_s;

	typedef struct packed {
		logic [`SRP_TMR_W-1:0] cnt;
	} srp_timer_s;

endpackage : srp_pkg

/* hw/srp_sync.sv */
// Two-flop synchroniser for the four pins from the host side
`timescale 1ns/1ps
`default_nettype none

module srp_sync
	import srp_pkg::*;
(
	input  wire logic       clock,     // Core clock
	input  wire logic       sys_rst,   // Synchronous reset
	input  wire logic       clk_en,    // Freezes state when low
	input  wire logic [3:0] pins_in,   // {pdn, csn, sdi, sclk} raw
	output logic      [3:0] pins_sync  // Same order, resynchronised
);

	srp_sync_s r;       // Registered state
	srp_sync_s next_r;  // Next state

	// ------------------------------------------------------------------
	// Next state: first stage feeds only the second stage
	// ------------------------------------------------------------------
	always_comb
	begin
		next_r        = r;
		next_r.meta   = pins_in;
		next_r.stable = r.meta;
	end

	// ------------------------------------------------------------------
	// State register
	// ------------------------------------------------------------------
	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			r <= {`SRP_SYNC_RST, `SRP_SYNC_RST};
		end
		else if (clk_en)
		begin
			r <= next_r;
		end
	end

	assign pins_sync = r.stable;

endmodule : srp_sync

`default_nettype wire

/* hw/srp_delay_timer.sv */
// Down-counter that times the sequencer steps and resets
`timescale 1ns/1ps
`default_nettype none

module srp_delay_timer
	import srp_pkg::*;
(
	input  wire logic                  clock,    // Core clock
	input  wire logic                  sys_rst,  // Synchronous reset
	input  wire logic                  clk_en,   // Freezes state when low
	input  wire logic                  load,     // Start a new wait
	input  wire logic [`SRP_TMR_W-1:0] load_val, // Cycles to wait
	output logic                       done      // Count has run out
);

	srp_timer_s r;       // Registered state
	srp_timer_s next_r;  // Next state

	// ------------------------------------------------------------------
	// Load wins over counting
	// ------------------------------------------------------------------
	always_comb
	begin
		next_r = r;
		if (load)
		begin
			next_r.cnt = load_val;
		end
		else if (r.cnt != '0)
		begin
			next_r.cnt = r.cnt - `SRP_TMR_W'(1);
		end
	end

	// ------------------------------------------------------------------
	// State register
	// ------------------------------------------------------------------
	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			r <= '0;
		end
		else if (clk_en)
		begin
			r <= next_r;
		end
	end

	assign done = (r.cnt == '0);

endmodule : srp_delay_timer

`default_nettype wire

/* verification/srp_chk.sv */
// Checker on the serial port and mode outputs
`timescale 1ns/1ps
`default_nettype none

module srp_chk (
	input wire logic       clock,
	input wire logic       sys_rst,
	input wire logic       sclk,
	input wire logic       chip_select_n,
	input wire logic       power_down_pin,
	input wire logic       sdo,
	input wire logic       sdo_oe,
	input wire logic       low_power_regulator,
	input wire logic       xtal_osc_on,
	input wire logic       synth_on,
	input wire logic       cal_active,
	input wire logic       pa_on,
	input wire logic       tx_active,
	input wire logic [3:0] radio_state
);
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);

	a_desel_pull_up: assert property (
		chip_select_n [*5] |-> sdo && !sdo_oe)
		else $error("sdo not released");
	a_pdn_all_off: assert property (
		power_down_pin [*5] |->
		radio_state == 4'h0 && !sdo_oe && !xtal_osc_on)
		else $error("shutdown not entered");
	a_por_start: assert property (
		$fell(power_down_pin) |-> ##[2:5] radio_state == 4'h1)
		else $error("no power-on reset");
	a_reset_ready: assert property (
		(radio_state == 4'h1 || radio_state == 4'hb) ##1
		radio_state == 4'h3 |-> ##[0:1] xtal_osc_on && !synth_on)
		else $error("reset did not end in ready");
	a_tune_xtal: assert property (
		synth_on |-> xtal_osc_on)
		else $error("synth without crystal");
	a_tx_after_ramp: assert property (
		$rose(tx_active) |-> $past(radio_state) == 4'h4 && pa_on)
		else $error("transmit without ramp");
	a_cal_in_path: assert property (
		cal_active |-> radio_state == 4'h7 && synth_on && xtal_osc_on)
		else $error("calibration out of place");
	a_sdo_on_fall: assert property (
		$changed(sdo) && sdo_oe && $past(sdo_oe) && !chip_select_n |->
		!$past(sclk, 3))
		else $error("sdo moved off a falling edge");
	a_lp_standby: assert property (
		low_power_regulator |-> radio_state == 4'h3 && !xtal_osc_on)
		else $error("low-power regulator misused");
endmodule : srp_chk

bind srp_mode_ctrl srp_chk chk_u (.*);

`default_nettype wire

/* verification/srp_host.sv */
// Host model: serial master paced by the core clock
`timescale 1ns/1ps
`default_nettype none

module srp_host (
	input  wire logic clock,         // Paces serial edges, 4 ns period
	output logic      sclk,          // Idle low between frames
	output logic      sdi,           // Data toward the port
	output logic      chip_select_n, // Frame select, active low
	input  wire logic sdo            // Data from the port
);
	logic [7:0] wbuf [0:3]; // Bytes sent after the header
	logic [7:0] rbuf [0:3]; // Bytes collected from sdo

	initial
	begin
		sclk = 1'b0;
		sdi = 1'b1;
		chip_select_n = 1'b1;
	end

	// Header plus n bytes, MSB first, select dropped while clock high
	task automatic frame(input logic wr, input logic [6:0] a, input int n);
		logic [7:0] b;
		chip_select_n <= 1'b0;
		repeat (4) @(posedge clock);
		for (int i = 0; i < 8 * (n + 1); i++)
		begin
			b = (i < 8) ? {wr, a} : wbuf[i / 8 - 1];
			sdi <= b[7 - i % 8];
			repeat (4) @(posedge clock);
			sclk <= 1'b1;
			repeat (4) @(posedge clock);
			if (i >= 8)
				rbuf[i / 8 - 1][7 - i % 8] = sdo;
			if (i == 8 * n + 7)
			begin
				chip_select_n <= 1'b1; // Keeps D0, no next D7
				repeat (2) @(posedge clock);
			end
			sclk <= 1'b0;
		end
		repeat (24) @(posedge clock); // Select high gap
		sdi <= ~sdi; // Released line shows no stale value
	endtask : frame
endmodule : srp_host

`default_nettype wire

/* verification/srp_mode_ctrl_test.sv */
// Self-checking bench for the serial port and mode sequencer
`timescale 1ns/1ps
`default_nettype none

module srp_mode_ctrl_test
	import srp_pkg::*;
;
	logic clock, sys_rst, power_down_pin, sdo, sdo_oe, cal_seen;
	logic low_power_regulator, main_regulator, wake_timer_on;
	logic battery_detect_on, xtal_osc_on, synth_on, cal_active;
	logic pa_on, tx_active;
	logic [3:0] radio_state;
	wire logic  sclk, sdi, chip_select_n;
	wire logic  clk_en = 1'b1;
	logic [7:0] e [0:3];  // Expected burst bytes
	logic [7:0] m;        // Mode byte under test
	logic [6:0] a;        // Burst start address
	logic [7:0] lvl_tab [0:4] = '{8'h00, 8'h40, 8'h20, 8'h01, 8'h02};
	int         n, seed;
	int         fail_count = 0;
	int         cmp_count = 0;

	srp_mode_ctrl #(.POR_CYCLES(20), .SOFT_CYCLES(10), .XTAL_CYCLES(12),
		.CAL_CYCLES(6), .SETTLE_CYCLES(8)) dut_u (.*);
	srp_host host_u (.*);

	initial
	begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end

	always @(posedge clock)
		if (cal_active)
			cal_seen <= 1'b1;

	// Expected {lp, wake, battery, crystal, synth} for an idle mode
	function automatic logic [4:0] lvl(input logic [7:0] v);
		return {v == 8'h00 || v == 8'h40, v[6], v[5], v[0] | v[1], v[1]};
	endfunction : lvl

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("unexpected at %0t: %h vs %h", $time, seen, exp);
		end
	endtask : chk

	task automatic wr(input logic [6:0] ad, input logic [7:0] d);
		host_u.wbuf[0] = d;
		host_u.frame(1'b1, ad, 1);
	endtask : wr

	task automatic rd(input logic [6:0] ad, input logic [7:0] exp);
		host_u.wbuf[0] = 8'($random(seed));
		host_u.frame(1'b0, ad, 1);
		chk(host_u.rbuf[0], exp);
	endtask : rd

	task automatic wt(input logic [3:0] s);
		for (int i = 0; i < 3000 && radio_state !== s; i++)
			@(posedge clock);
		chk({4'h0, radio_state}, {4'h0, s});
	endtask : wt

	task stop_test;
		if (fail_count == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : stop_test

	initial
	begin
		#200000;
		fail_count++;
		stop_test();
	end

	initial
	begin
		sys_rst = 1'b1;
		power_down_pin = 1'b1;
		cal_seen = 1'b0;
		seed = 32'h8c03b95f;
		repeat (2) @(posedge clock);
		sys_rst <= 1'b0;
		repeat (4) @(posedge clock);
		power_down_pin <= 1'b0;
		wt(4'h3);
		// Interrupt status read first after power-on reset
		rd(7'h03, 8'h00);
		rd(7'h04, 8'h00);
		rd(7'h07, 8'h01);
		rd(7'h62, 8'h00);
		// Random bursts written, then read back
		repeat (4)
		begin
			a = 7'h60 + 7'($unsigned($random(seed)) % 16);
			n = 1 + $unsigned($random(seed)) % 4;
			for (int k = 0; k < 4; k++)
				host_u.wbuf[k] = 8'($random(seed));
			e = host_u.wbuf;
			host_u.frame(1'b1, a, n);
			for (int k = 0; k < 4; k++)
				host_u.wbuf[k] = 8'($random(seed));
			host_u.frame(1'b0, a, n);
			for (int k = 0; k < n; k++)
				chk(host_u.rbuf[k], e[k]);
		end
		// Burst wraps from the top address to zero
		host_u.wbuf[1] = 8'h3c;
		host_u.frame(1'b1, 7'h7f, 2);
		rd(7'h00, 8'h3c);
		// Every idle mode and its enables
		foreach (lvl_tab[j])
		begin
			m = lvl_tab[j];
			wr(7'h07, m);
			repeat (8) @(posedge clock);
			chk({3'h0, low_power_regulator, wake_timer_on, battery_detect_on,
				xtal_osc_on, synth_on}, {3'h0, lvl(m)});
			chk({7'h0, main_regulator},
				{7'h0, m != 8'h00 && m != 8'h40});
		end
		// Transmit from standby, with and without calibration
		for (int c = 1; c >= 0; c--)
		begin
			wr(7'h55, c ? 8'h08 : 8'h00);
			wr(7'h07, 8'h00);
			cal_seen = 1'b0;
			wr(7'h07, 8'h08);
			wt(4'hc);
			chk({7'h0, cal_seen}, 8'(c));
		end
		// Transmit from ready and from tune, fewer steps
		for (int t = 1; t <= 2; t++)
		begin
			wr(7'h07, 8'(t));
			wr(7'h07, 8'(t) | 8'h08);
			wt(4'hc);
		end
		wr(7'h07, 8'h80);
		wt(4'h3);
		rd(7'h55, 8'h08);
		// Shutdown loses registers
		wr(7'h62, 8'ha5);
		power_down_pin <= 1'b1;
		repeat (8) @(posedge clock);
		chk({4'h0, radio_state}, 8'h00);
		power_down_pin <= 1'b0;
		wt(4'h3);
		rd(7'h62, 8'h00);
		stop_test();
	end
endmodule : srp_mode_ctrl_test

`default_nettype wire
